// >>> logic/cg_pkg.sv
// Package with constants and carrier types for the CPU clock generator.
package cg_pkg;

  // Source periods in one CPU clock period, and the counter's last value.
  localparam int unsigned DIV_RATIO   = 3;
  localparam logic [1:0]  DIV_LAST    = 2'h2;
  localparam logic [1:0]  DIV_FIRST   = 2'h0;

  // Depth of the pin synchronisers.
  localparam int unsigned SYNC_STAGES = 3;

  // Values after reset.
  localparam logic        RST_CPU_CLK   = 1'h1;
  localparam logic        RST_PERIPH    = 1'h1;
  localparam logic        RST_CPU_RESET = 1'h1;
  localparam logic        RST_READY     = 1'h0;
  localparam logic        RST_PIN       = 1'h0;

  // Pin inputs after synchronisation, in one carrier.
  typedef struct packed {
    logic crystal;
    logic ext_freq;
    logic source_select;
    logic phase_sync;
    logic ready_a;
    logic ready_b;
    logic grant_a_n;
    logic grant_b_n;
    logic reset_req_n;
    logic stage_select;
  } cg_pins_s;

  localparam int unsigned PIN_W = $bits(cg_pins_s);

  // All state of the clock generator apart from the pin synchroniser.
  typedef struct packed {
    logic [1:0] div_cnt;
    logic       src_prev;
    logic       cpu_clk;
    logic       periph_clk;
    logic       cpu_reset;
    logic       rdy_f1;
    logic       ready;
    logic       osc;
  } cg_state_s;

endpackage

// >>> logic/cg_sync.sv
// Three-stage pin synchroniser, passing a change once stages 2 and 3 agree.
`timescale 1ns/1ps
module cg_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } cg_sync_s;

  cg_sync_s st_q;
  cg_sync_s st_d;

  // The first stage feeds only the second; the filter looks at two and three.
  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = pin_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (st_q.s2[i] == st_q.s3[i])
      begin
        st_d.level[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_q <= '{default: {WIDTH{cg_pkg::RST_PIN}}};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign level_o = st_q.level;

endmodule // cg_sync

// >>> logic/cg_clock_gen.sv
// CPU clock, peripheral clock, reset and ready generator.
`timescale 1ns/1ps
module cg_clock_gen (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic crystal_pin_a_i,
  input  wire logic external_freq_in_i,
  input  wire logic source_select_i,
  input  wire logic clock_phase_sync_i,
  input  wire logic bus_ready_in_a_i,
  input  wire logic bus_ready_in_b_i,
  input  wire logic bus_grant_qual_a_n_i,
  input  wire logic bus_grant_qual_b_n_i,
  input  wire logic reset_request_n_i,
  input  wire logic ready_stage_select_i,
  output logic      cpu_clk_o,
  output logic      periph_clk_o,
  output logic      cpu_reset_o,
  output logic      cpu_ready_o,
  output logic      crystal_freq_out_o
);

  cg_pkg::cg_pins_s  pin_raw;
  cg_pkg::cg_pins_s  pin_s;
  cg_pkg::cg_state_s st_q;
  cg_pkg::cg_state_s st_d;
  logic              src_sel;
  logic              src_rise;
  logic              qual_rdy;
  logic              cpu_rise;
  logic              cpu_fall;

  assign pin_raw = '{crystal:       crystal_pin_a_i,
                     ext_freq:      external_freq_in_i,
                     source_select: source_select_i,
                     phase_sync:    clock_phase_sync_i,
                     ready_a:       bus_ready_in_a_i,
                     ready_b:       bus_ready_in_b_i,
                     grant_a_n:     bus_grant_qual_a_n_i,
                     grant_b_n:     bus_grant_qual_b_n_i,
                     reset_req_n:   reset_request_n_i,
                     stage_select:  ready_stage_select_i};

  // Every pin is asynchronous to clk_i, so all of them share one synchroniser.
  cg_sync #(
    .WIDTH (cg_pkg::PIN_W)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .pin_i   (pin_raw),
    .level_o (pin_s)
  );

  // The source must stay well below half of clk_i or its edges are missed.
  assign src_sel  = pin_s.source_select ? pin_s.ext_freq
                                        : pin_s.crystal;
  assign src_rise = src_sel & ~st_q.src_prev;
  assign qual_rdy = (pin_s.ready_a & ~pin_s.grant_a_n)
                  | (pin_s.ready_b & ~pin_s.grant_b_n);

  always_comb
  begin
    st_d          = st_q;
    st_d.src_prev = src_sel;
    st_d.osc      = pin_s.crystal;
    if (pin_s.phase_sync)
    begin
      st_d.div_cnt    = cg_pkg::DIV_FIRST;
      st_d.cpu_clk    = 1'h1;
      st_d.periph_clk = 1'h1;
    end
    else if (src_rise)
    begin
      // High for the source period after the last count, low for two.
      if (st_q.div_cnt == cg_pkg::DIV_LAST)
      begin
        st_d.div_cnt = cg_pkg::DIV_FIRST;
      end
      else
      begin
        st_d.div_cnt = st_q.div_cnt + 2'h1;
      end
      st_d.cpu_clk = (st_d.div_cnt == cg_pkg::DIV_FIRST);
    end
    cpu_rise = st_d.cpu_clk & ~st_q.cpu_clk;
    cpu_fall = st_q.cpu_clk & ~st_d.cpu_clk;
    if (cpu_rise)
    begin
      st_d.rdy_f1 = qual_rdy;
    end
    if (cpu_fall)
    begin
      if (!pin_s.phase_sync)
      begin
        st_d.periph_clk = ~st_q.periph_clk;
      end
      st_d.cpu_reset = ~pin_s.reset_req_n;
      if (pin_s.stage_select)
      begin
        st_d.ready = qual_rdy;
      end
      else
      begin
        // A request that dropped since the rising edge clears at once.
        st_d.ready = st_q.rdy_f1 & qual_rdy;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_q <= '{div_cnt:    cg_pkg::DIV_FIRST,
                src_prev:   cg_pkg::RST_PIN,
                cpu_clk:    cg_pkg::RST_CPU_CLK,
                periph_clk: cg_pkg::RST_PERIPH,
                cpu_reset:  cg_pkg::RST_CPU_RESET,
                rdy_f1:     cg_pkg::RST_READY,
                ready:      cg_pkg::RST_READY,
                osc:        cg_pkg::RST_PIN};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign cpu_clk_o          = st_q.cpu_clk;
  assign periph_clk_o       = st_q.periph_clk;
  assign cpu_reset_o        = st_q.cpu_reset;
  assign cpu_ready_o        = st_q.ready;
  assign crystal_freq_out_o = st_q.osc;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_count_wrap;
    src_rise && !pin_s.phase_sync && st_q.div_cnt == cg_pkg::DIV_LAST;
  endsequence

  sequence s_count_step;
    src_rise && !pin_s.phase_sync && st_q.div_cnt != cg_pkg::DIV_LAST;
  endsequence

  property p_sync_hold;
    pin_s.phase_sync |=> cpu_clk_o && periph_clk_o && st_q.div_cnt == 2'h0;
  endproperty
  a_sync_hold: assert property (p_sync_hold)
    else $error("CPU clock not held high during phase sync.");

  property p_high_slot;
    s_count_wrap |=> cpu_clk_o;
  endproperty
  a_high_slot: assert property (p_high_slot)
    else $error("CPU clock not high after the divider wraps.");

  property p_low_slot;
    s_count_step |=> !cpu_clk_o;
  endproperty
  a_low_slot: assert property (p_low_slot)
    else $error("CPU clock not low in the two counting slots.");

  property p_no_source_no_change;
    !src_rise && !pin_s.phase_sync |=> $stable(cpu_clk_o);
  endproperty
  a_no_source_no_change: assert property (p_no_source_no_change)
    else $error("CPU clock changed without a source edge.");

  property p_pclk_on_fall;
    !$past(pin_s.phase_sync) && $changed(periph_clk_o) |-> $fell(cpu_clk_o);
  endproperty
  a_pclk_on_fall: assert property (p_pclk_on_fall)
    else $error("Peripheral clock moved off a CPU clock fall.");

  property p_reset_follow;
    $fell(cpu_clk_o) |-> cpu_reset_o == !$past(pin_s.reset_req_n);
  endproperty
  a_reset_follow: assert property (p_reset_follow)
    else $error("Reset output is not the inverted request.");

  property p_ready_single;
    $fell(cpu_clk_o) && $past(pin_s.stage_select)
      |-> cpu_ready_o == $past(qual_rdy);
  endproperty
  a_ready_single: assert property (p_ready_single)
    else $error("Single-stage ready did not take the request.");

  property p_ready_two;
    $rose(cpu_ready_o) && !$past(pin_s.stage_select) |-> $past(st_q.rdy_f1);
  endproperty
  a_ready_two: assert property (p_ready_two)
    else $error("Two-stage ready rose without the rising-edge stage.");

  property p_ready_stable;
    !$fell(cpu_clk_o) |-> $stable(cpu_ready_o) && $stable(cpu_reset_o);
  endproperty
  a_ready_stable: assert property (p_ready_stable)
    else $error("Ready or reset changed away from a CPU clock fall.");

  property p_osc;
    pin_s.source_select |=> crystal_freq_out_o == $past(pin_s.crystal);
  endproperty
  a_osc: assert property (p_osc)
    else $error("Crystal output lost while the external source is chosen.");

endmodule // cg_clock_gen

// >>> verif/cg_src_model.sv
// Far-side model: free-running crystal and external frequency sources.
`timescale 1ns/1ps
module cg_src_model #(
  parameter int unsigned XTAL_HALF = 4,
  parameter int unsigned EXT_HALF  = 3
) (
  input  wire logic clk_i,
  output logic      crystal_o,
  output logic      ext_freq_o
);
  int unsigned xc;
  int unsigned ec;

  initial
  begin
    crystal_o  = 1'h0;
    ext_freq_o = 1'h0;
    xc         = 0;
    ec         = 0;
  end

  // Each level lasts whole cycles so that no pin synchroniser misses one.
  always @(posedge clk_i)
  begin
    xc <= (xc == XTAL_HALF - 1) ? 0 : xc + 1;
    ec <= (ec == EXT_HALF - 1) ? 0 : ec + 1;
    if (xc == XTAL_HALF - 1)
      crystal_o <= ~crystal_o;
    if (ec == EXT_HALF - 1)
      ext_freq_o <= ~ext_freq_o;
  end
endmodule // cg_src_model

// >>> verif/cg_clock_gen_bench.sv
// Self-checking bench for the CPU clock generator.
`timescale 1ns/1ps
module cg_clock_gen_bench;
  localparam int XH = 4;
  localparam int EH = 3;
  logic        clk_i;
  logic        rst_b_i;
  logic        xtal;
  logic        external_freq_in;
  logic        sel;
  logic        psync;
  logic        rdy_a;
  logic        rdy_b;
  logic        qa_n;
  logic        qb_n;
  logic        res_n;
  logic        stg;
  logic        cpu_clk;
  logic        periph;
  logic        cpu_reset;
  logic        cpu_ready;
  logic        osc;
  logic        pr;
  logic        ps;
  logic        pc;
  logic        po;
  logic [15:0] lfsr;
  logic        f1;
  logic [2:0]  hist[$];
  int          failures;
  int          check_count;
  int          cycles;
  int          hi;
  int          lo;
  int          n;

  cg_src_model #(.XTAL_HALF(XH), .EXT_HALF(EH)) src (.clk_i(clk_i),
    .crystal_o(xtal), .ext_freq_o(external_freq_in));

  cg_clock_gen dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .crystal_pin_a_i(xtal),
    .external_freq_in_i(external_freq_in), .source_select_i(sel),
    .clock_phase_sync_i(psync), .bus_ready_in_a_i(rdy_a),
    .bus_ready_in_b_i(rdy_b), .bus_grant_qual_a_n_i(qa_n),
    .bus_grant_qual_b_n_i(qb_n), .reset_request_n_i(res_n),
    .ready_stage_select_i(stg), .cpu_clk_o(cpu_clk), .periph_clk_o(periph),
    .cpu_reset_o(cpu_reset), .cpu_ready_o(cpu_ready),
    .crystal_freq_out_o(osc));

  initial clk_i = 1'h0;
  always #25 clk_i = ~clk_i;

  task automatic close_out();
    $display("Checks %0d, failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic got, input logic exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  task automatic checkn(input int got, input int exp, input string msg);
    check_count++;
    if (got != exp)
    begin
      failures++;
      $display("Error at %0t: %s got %0d want %0d", $time, msg, got, exp);
    end
  endtask

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic logic qual();
    return (rdy_a & ~qa_n) | (rdy_b & ~qb_n);
  endfunction

  function automatic logic lvl(input bit p);
    return p ? periph : cpu_clk;
  endfunction

  // Skips the partial phase in progress, then times one full high and low.
  task automatic meas(input bit p, output int h, output int l);
    int k;
    h = 0;
    l = 0;
    k = 0;
    while (lvl(p) !== 1'h0 && k < 400) begin @(negedge clk_i); k++; end
    while (lvl(p) !== 1'h1 && k < 400) begin @(negedge clk_i); k++; end
    while (lvl(p) === 1'h1 && k < 400) begin @(negedge clk_i); k++; h++; end
    while (lvl(p) === 1'h0 && k < 400) begin @(negedge clk_i); k++; l++; end
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      $display("Error at %0t: run hung", $time);
      close_out();
    end
  end

  // Ready and reset may only move on the cycle the CPU clock falls.
  always @(negedge clk_i)
  begin
    if (rst_b_i === 1'h1 && (cpu_ready !== pr || cpu_reset !== ps))
      check(pc === 1'h1 && cpu_clk === 1'h0, 1'h1, "edge off fall");
    pr <= cpu_ready;
    ps <= cpu_reset;
    pc <= cpu_clk;
  end

  // Reference model: a pin reaches the outputs five cycles later, and
  // ready and reset move only where the CPU clock falls.
  always @(negedge clk_i)
  begin
    hist.push_back({stg, qual(), res_n});
    if (hist.size() > 6)
      void'(hist.pop_front());
    if (rst_b_i !== 1'h1)
    begin
      f1 = 1'h0;
    end
    else if (cycles > 12 && hist.size() == 6)
    begin
      if (pc === 1'h0 && cpu_clk === 1'h1)
        f1 = hist[0][1];
      if (pc === 1'h1 && cpu_clk === 1'h0)
      begin
        check(cpu_reset, ~hist[0][0], "model reset");
        check(cpu_ready, hist[0][2] ? hist[0][1] : (f1 & hist[0][1]),
              "model ready");
      end
    end
  end

  initial
  begin
    rst_b_i = 1'h0; sel = 1'h0; psync = 1'h0; rdy_a = 1'h0; rdy_b = 1'h0;
    qa_n = 1'h1; qb_n = 1'h1; res_n = 1'h1; stg = 1'h0; lfsr = 16'hf920;
    @(negedge clk_i);
    check(cpu_clk, 1'h1, "reset clock");
    check(periph, 1'h1, "reset pclk");
    check(cpu_reset, 1'h1, "reset out");
    check(osc, 1'h0, "reset osc");
    check(cpu_ready, 1'h0, "reset ready");
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'h1;
    repeat (60) @(negedge clk_i);
    check(cpu_reset, 1'h0, "reset release");
    meas(0, hi, lo);
    checkn(hi, 2 * XH, "xtal high");
    checkn(lo, 4 * XH, "xtal low");
    meas(1, hi, lo);
    checkn(hi, 6 * XH, "pclk high");
    checkn(lo, 6 * XH, "pclk low");
    @(posedge clk_i) sel <= 1'h1;
    repeat (80) @(negedge clk_i);
    meas(0, hi, lo);
    checkn(hi, 2 * EH, "efi high");
    checkn(lo, 4 * EH, "efi low");
    meas(1, hi, lo);
    checkn(hi + lo, 12 * EH, "pclk period");
    n = 0;
    po = osc;
    repeat (40) begin @(negedge clk_i); n += (osc !== po); po = osc; end
    checkn(n, 40 / XH, "osc edges");
    // Phase sync follows the external input, as the system must keep it.
    @(posedge external_freq_in); @(posedge clk_i) psync <= 1'h1;
    repeat (10) @(negedge clk_i);
    n = 0;
    repeat (30) begin @(negedge clk_i); n += (cpu_clk & periph) === 1'h1; end
    checkn(n, 30, "sync hold");
    @(posedge external_freq_in); @(posedge clk_i) psync <= 1'h0;
    meas(0, hi, lo);
    checkn(hi, 2 * EH, "sync restart");
    checkn(lo, 4 * EH, "sync restart low");
    @(posedge clk_i) res_n <= 1'h0;
    repeat (60) @(negedge clk_i);
    check(cpu_reset, 1'h1, "reset asserted");
    @(posedge clk_i) res_n <= 1'h1;
    repeat (60) @(negedge clk_i);
    check(cpu_reset, 1'h0, "reset cleared");
    // Single master: only grant a is enabled; b's ready must be ignored.
    @(posedge clk_i) {stg, qa_n, qb_n, rdy_b} <= 4'h3;
    repeat (60) @(negedge clk_i);
    check(cpu_ready, 1'h0, "unqualified ready");
    @(posedge clk_i) rdy_a <= 1'h1;
    repeat (60) @(negedge clk_i);
    check(cpu_ready, 1'h1, "slave ready");
    repeat (24)
    begin
      lfsr = lfsr_next(lfsr);
      @(posedge clk_i) {stg, rdy_a, rdy_b, qa_n, qb_n} <= lfsr[4:0];
      repeat (60) @(negedge clk_i);
      check(cpu_ready, qual(), "ready");
    end
    close_out();
  end
endmodule // cg_clock_gen_bench
